// ### hw/supply_mode_pkg.sv
// Package: addresses, bit positions, reset values and timing for supply mode control
package supply_mode_pkg;
    localparam logic [15:0] ADDR_SUPPLY_SEL = 16'hFF01;
    localparam logic [15:0] ADDR_LCD_CTL = 16'hFF60;
    localparam int BIT_BOOSTER_POWER_CTL = 0;
    localparam int BIT_OSC_REG_SUPPLY_SEL = 2;
    localparam int BIT_ADC_SUPPLY_SEL = 3;
    localparam logic RST_BOOSTER_POWER_CTL = 1'b0;
    localparam logic RST_OSC_REG_SUPPLY_SEL = 1'b0;
    localparam logic RST_ADC_SUPPLY_SEL = 1'b0;
    localparam logic [3:0] RST_SUPPLY_SEL_NIBBLE = 4'h0;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETTLE_TIME_MS = 100;
    localparam int SETTLE_CYCLES = SETTLE_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int SETTLE_CNT_W = 24;
endpackage

// ### hw/rail_settle_timer.sv
// Module: settling timer that reports when the boosted rail has had time to settle
`timescale 1ns/1ps
module rail_settle_timer
    import supply_mode_pkg::*;
#(
    parameter int SETTLE_COUNT = SETTLE_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic booster_on_in,
    output logic rail_settled_out
);
    logic [SETTLE_CNT_W-1:0] cnt_q;
    logic [SETTLE_CNT_W-1:0] cnt_d;
    logic settled_q;
    logic settled_d;

    // Status only; nothing blocks a select write on it
    always_comb begin
        cnt_d = cnt_q;
        settled_d = settled_q;
        if (!booster_on_in) begin
            cnt_d = '0;
            settled_d = 1'b0;
        end else if (!settled_q) begin
            if (cnt_q >= SETTLE_CNT_W'(SETTLE_COUNT - 1)) begin
                settled_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            cnt_q <= '0;
            settled_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            settled_q <= settled_d;
        end
    end

    assign rail_settled_out = settled_q;
endmodule // rail_settle_timer

// ### hw/supply_mode_select_ctrl.sv
// Module: booster enable and supply selects for oscillator regulator and converter
// How it works
// - Booster runs while booster enable bit is one, stops when zero.
// - Select one routes boosted rail to its circuit; zero routes external supply.
// - Two independent selects, each switching only its own circuit.
// - Reset leaves both circuits on the external supply.
// - LCD drive voltages reach the driver only while booster enable is one.
// - Booster enable is bit 0 at FF60H, read/write, reset to zero.
// - Oscillator regulator select is bit 2 at FF01H, readable, reset zero.
// - Converter select is bit 3 at FF01H, readable, reset zero.
`timescale 1ns/1ps
module supply_mode_select_ctrl
    import supply_mode_pkg::*;
#(
    parameter int SETTLE_COUNT = SETTLE_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [15:0] io_addr_in,
    input wire logic [3:0] io_wdata_in,
    input wire logic io_wr_in,
    input wire logic io_rd_in,
    output logic [3:0] io_rdata_out,
    output logic io_hit_out,
    output logic booster_run_out,
    output logic lcd_drive_en_out,
    output logic osc_reg_on_boost_out,
    output logic adc_on_boost_out,
    output logic rail_settled_out,
    output logic boost_unpowered_out
);
    logic booster_power_ctl_q;
    logic booster_power_ctl_d;
    logic osc_reg_supply_sel_q;
    logic osc_reg_supply_sel_d;
    logic adc_supply_sel_q;
    logic adc_supply_sel_d;
    logic [3:0] rdata_q;
    logic [3:0] rdata_d;
    logic hit_q;
    logic hit_d;
    logic sel_hit;
    logic lcd_hit;

    assign sel_hit = (io_addr_in == ADDR_SUPPLY_SEL);
    assign lcd_hit = (io_addr_in == ADDR_LCD_CTL);

    // Other FF60H bits belong to the LCD block; only bit 0 lives here
    always_comb begin
        booster_power_ctl_d = booster_power_ctl_q;
        osc_reg_supply_sel_d = osc_reg_supply_sel_q;
        adc_supply_sel_d = adc_supply_sel_q;
        if (io_wr_in && lcd_hit) begin
            booster_power_ctl_d = io_wdata_in[BIT_BOOSTER_POWER_CTL];
        end
        if (io_wr_in && sel_hit) begin
            osc_reg_supply_sel_d = io_wdata_in[BIT_OSC_REG_SUPPLY_SEL];
            adc_supply_sel_d = io_wdata_in[BIT_ADC_SUPPLY_SEL];
        end
    end

    // Unused bits of FF01H read as zero
    always_comb begin
        rdata_d = 4'h0;
        hit_d = 1'b0;
        if (io_rd_in && sel_hit) begin
            rdata_d[BIT_OSC_REG_SUPPLY_SEL] = osc_reg_supply_sel_q;
            rdata_d[BIT_ADC_SUPPLY_SEL] = adc_supply_sel_q;
            hit_d = 1'b1;
        end else if (io_rd_in && lcd_hit) begin
            rdata_d[BIT_BOOSTER_POWER_CTL] = booster_power_ctl_q;
            hit_d = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            booster_power_ctl_q <= RST_BOOSTER_POWER_CTL;
            osc_reg_supply_sel_q <= RST_OSC_REG_SUPPLY_SEL;
            adc_supply_sel_q <= RST_ADC_SUPPLY_SEL;
            rdata_q <= RST_SUPPLY_SEL_NIBBLE;
            hit_q <= 1'b0;
        end else begin
            booster_power_ctl_q <= booster_power_ctl_d;
            osc_reg_supply_sel_q <= osc_reg_supply_sel_d;
            adc_supply_sel_q <= adc_supply_sel_d;
            rdata_q <= rdata_d;
            hit_q <= hit_d;
        end
    end

    rail_settle_timer #(
        .SETTLE_COUNT(SETTLE_COUNT)
    ) u_settle (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .booster_on_in(booster_power_ctl_q),
        .rail_settled_out(rail_settled_out)
    );

    assign io_rdata_out = rdata_q;
    assign io_hit_out = hit_q;
    assign booster_run_out = booster_power_ctl_q;
    assign lcd_drive_en_out = booster_power_ctl_q;
    assign osc_reg_on_boost_out = osc_reg_supply_sel_q;
    assign adc_on_boost_out = adc_supply_sel_q;
    // Diagnostic only: flags software breaking the booster-first ordering
    assign boost_unpowered_out = (osc_reg_supply_sel_q | adc_supply_sel_q) &
        ~booster_power_ctl_q;
endmodule // supply_mode_select_ctrl

// ### verif/supply_mode_select_ctrl_asserts.sv
// Port checks for the supply mode control block
`timescale 1ns/1ps
module supply_mode_select_ctrl_asserts (
    input logic clk_in,
    input logic rst_b_in,
    input logic [15:0] io_addr_in,
    input logic [3:0] io_wdata_in,
    input logic io_wr_in,
    input logic io_rd_in,
    input logic [3:0] io_rdata_out,
    input logic io_hit_out,
    input logic booster_run_out,
    input logic lcd_drive_en_out,
    input logic osc_reg_on_boost_out,
    input logic adc_on_boost_out,
    input logic rail_settled_out,
    input logic boost_unpowered_out
);
    wire lw = io_wr_in && io_addr_in == 16'hFF60;
    wire sw = io_wr_in && io_addr_in == 16'hFF01;
    wire sr = io_rd_in && !io_wr_in && io_addr_in == 16'hFF01;
    wire br = io_rd_in && io_addr_in != 16'hFF01 && io_addr_in != 16'hFF60;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    AST_RUN: assert property (lw |=> booster_run_out == $past(io_wdata_in[0]))
        else $error("booster");
    AST_LCD: assert property (lcd_drive_en_out == booster_run_out)
        else $error("lcd drive");
    AST_OSC: assert property (sw |=> osc_reg_on_boost_out == $past(io_wdata_in[2]))
        else $error("osc select");
    AST_ADC: assert property (sw |=> adc_on_boost_out == $past(io_wdata_in[3]))
        else $error("adc select");
    AST_IND: assert property (lw |=> $stable(osc_reg_on_boost_out) && $stable(adc_on_boost_out))
        else $error("select moved");
    AST_RST: assert property ($rose(rst_b_in) |-> !(osc_reg_on_boost_out | adc_on_boost_out))
        else $error("reset mode");
    AST_RD: assert property (sr |=> io_hit_out && io_rdata_out ==
        {$past(adc_on_boost_out), $past(osc_reg_on_boost_out), 2'b00}) else $error("readback");
    AST_BAD: assert property (br |=> !io_hit_out && io_rdata_out == 4'h0)
        else $error("stray read");
    AST_UNP: assert property (boost_unpowered_out ==
        ((osc_reg_on_boost_out || adc_on_boost_out) && !booster_run_out))
        else $error("unpowered flag");
    AST_SDROP: assert property (!booster_run_out |=> !rail_settled_out)
        else $error("settled flag");
    cover property (lw ##1 booster_run_out);
    cover property (rail_settled_out && adc_on_boost_out);
    cover property (sw ##1 osc_reg_on_boost_out);
    cover property (br);
endmodule // supply_mode_select_ctrl_asserts

// ### verif/cpu_sw_model.sv
// Software model issuing nibble accesses and mode sequences
`timescale 1ns/1ps
module cpu_sw_model (
    input wire logic clk_in,
    output logic [15:0] a_out,
    output logic [3:0] d_out,
    output logic wr_out,
    output logic rd_out
);
    initial {wr_out, rd_out, a_out, d_out} = 22'h0;
    task acc(input logic w, input logic [15:0] a, input logic [3:0] d);
        @(posedge clk_in);
        {wr_out, rd_out, a_out, d_out} <= {w, !w, a, d};
        @(posedge clk_in);
        {wr_out, rd_out, a_out, d_out} <= {2'b00, ~a, ~d}; // Released bus never shows stale data
    endtask
    task boost(input logic [3:0] sel);
        acc(1, 16'hFF60, 4'h1);
        repeat (20) @(posedge clk_in);
        acc(1, 16'hFF01, sel);
    endtask
    task normal;
        acc(1, 16'hFF01, 4'h0);
        acc(1, 16'hFF60, 4'h0);
    endtask
endmodule // cpu_sw_model

// ### verif/supply_mode_select_ctrl_tb.sv
// Testbench for the supply mode control block
`timescale 1ns/1ps
module supply_mode_select_ctrl_tb;
    logic clk_in = 0, rst_b_in = 0, wr, rd, hit, run, lcd, osc, adc, settled, unp;
    logic [15:0] a;
    logic [3:0] d, rdata;
    int err_total = 0, n_checks = 0;
    wire [4:0] st = {hit, run, lcd, osc, adc};
    always #5 clk_in = ~clk_in;
    cpu_sw_model i_sw (.clk_in(clk_in), .a_out(a), .d_out(d), .wr_out(wr), .rd_out(rd));
    supply_mode_select_ctrl #(.SETTLE_COUNT(20)) i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .io_addr_in(a), .io_wdata_in(d), .io_wr_in(wr), .io_rd_in(rd), .io_rdata_out(rdata),
        .io_hit_out(hit), .booster_run_out(run), .lcd_drive_en_out(lcd),
        .osc_reg_on_boost_out(osc), .adc_on_boost_out(adc), .rail_settled_out(settled),
        .boost_unpowered_out(unp));
    task chk(input string n, input logic [4:0] e, input logic [4:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask
    task rdchk(input logic [15:0] ad, input logic [4:0] e);
        i_sw.acc(0, ad, 4'h0);
        #1 chk("read", e, {hit, rdata});
    endtask
    task t_reset;
        #1 chk("state", 5'h00, st);
        chk("aux", 5'h00, {3'b000, settled, unp});
        rdchk(16'hFF60, 5'h10);
        rdchk(16'hFF01, 5'h10);
    endtask
    task t_modes;
        i_sw.boost(4'h4);
        #1 chk("state", 5'h0E, st);
        chk("aux", 5'h02, {3'b000, settled, unp});
        rdchk(16'hFF60, 5'h11);
        rdchk(16'hFF01, 5'h14);
        i_sw.acc(1, 16'hFF01, 4'h8);
        #1 chk("state", 5'h0D, st);
        rdchk(16'hFF01, 5'h18);
        i_sw.normal;
        #1 chk("state", 5'h00, st);
        i_sw.acc(1, 16'hFF60, 4'hE);
        #1 chk("state", 5'h00, st);
        i_sw.acc(1, 16'hFF01, 4'h4);
        #1 chk("state", 5'h02, st);
        chk("aux", 5'h01, {3'b000, settled, unp});
        rdchk(16'hFF02, 5'h00);
    endtask
    task complete_run;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_in);
        rst_b_in <= 1;
        t_reset;
        t_modes;
        complete_run;
    end
endmodule // supply_mode_select_ctrl_tb
bind supply_mode_select_ctrl supply_mode_select_ctrl_asserts i_chk (.*);
